// [core/efi_pkg.sv]
// shared constants and types for the event flag interrupt logic
package efi_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          EFI_ADDR_W        = 7;
    localparam int          EFI_DATA_W        = 8;
    localparam int          EFI_NUM_FLAGS     = 10;
    localparam int          EFI_PAD_W         = 16;
    localparam logic [6:0]  EFI_OFS_EN_LOW    = 7'h03;
    localparam logic [6:0]  EFI_OFS_EN_HIGH   = 7'h04;
    localparam logic [6:0]  EFI_OFS_FLAG_LOW  = 7'h05;
    localparam logic [6:0]  EFI_OFS_FLAG_HIGH = 7'h06;
    localparam logic [6:0]  EFI_OFS_RT_LOW    = 7'h07;
    localparam logic [6:0]  EFI_OFS_RT_HIGH   = 7'h08;
    localparam logic [15:0] EFI_EN_RESET      = 16'h0000;
    localparam logic [15:0] EFI_RT_RESET      = 16'h0000;
    localparam logic [7:0]  EFI_RD_UNMAPPED   = 8'h00;
    // ------------------------------------------------------------
    // serial port framing
    // ------------------------------------------------------------
    localparam int          EFI_RW_BIT        = 7;
    localparam logic [3:0]  EFI_LAST_BIT      = 4'h7;

    // serial port states, gray along idle-instr-data-done
    typedef enum logic [1:0] {
        EFI_SP_IDLE  = 2'b00,
        EFI_SP_INSTR = 2'b01,
        EFI_SP_DATA  = 2'b11,
        EFI_SP_DONE  = 2'b10
    } efi_sp_state_t;

    // one register write from the serial port
    typedef struct packed {
        logic                  valid;
        logic [EFI_ADDR_W-1:0] addr;
        logic [EFI_DATA_W-1:0] data;
    } efi_wr_t;
endpackage

// [core/efi_flag_cell.sv]
// one event flag: edge latch, live readback and request term
`timescale 1ns/10ps
`default_nettype none
module efi_flag_cell
    import efi_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic rstn_in,
    input  wire logic soft_reset_in,
    input  wire logic enable_in,
    input  wire logic source_in,
    input  wire logic w1c_in,
    output logic      flag_out,
    output logic      pending_out
);
    logic prev;
    logic latched;
    logic next_prev;
    logic next_latched;
    logic rise;

    // ------------------------------------------------------------
    // latch logic; a rising edge in the clear cycle wins
    // ------------------------------------------------------------
    always_comb begin
        rise         = source_in & ~prev;
        next_prev    = source_in;
        next_latched = latched;
        if (w1c_in) begin
            next_latched = 1'b0;
        end
        if (enable_in && rise) begin
            next_latched = 1'b1;
        end
        if (soft_reset_in) begin
            next_latched = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            prev    <= 1'b0;
            latched <= 1'b0;
        end else begin
            prev    <= next_prev;
            latched <= next_latched;
        end
    end

    // disabled flag shows the live source and never requests
    assign flag_out    = enable_in ? latched : source_in;
    assign pending_out = enable_in & latched;

    property p_cell_set;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (enable_in && rise && !soft_reset_in) |=> latched;
    endproperty
    a_cell_set: assert property (p_cell_set) else $error("edge not latched");

    property p_cell_w1c;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (w1c_in && !(enable_in && rise)) |=> !latched;
    endproperty
    a_cell_w1c: assert property (p_cell_w1c) else $error("flag not cleared");
endmodule
`default_nettype wire

// [core/efi_serial_port.sv]
// three-wire serial control port: instruction byte then one data byte
`timescale 1ns/10ps
`default_nettype none
module efi_serial_port
    import efi_pkg::*;
(
    input  wire logic                  ref_clk_in,
    input  wire logic                  rstn_in,
    input  wire logic                  sclk_in,
    input  wire logic                  cs_n_in,
    input  wire logic                  sdio_in,
    input  wire logic [EFI_DATA_W-1:0] rd_data_in,
    output logic      [EFI_ADDR_W-1:0] rd_addr_out,
    output efi_wr_t                    wr_out,
    output logic                       sdio_out,
    output logic                       sdio_oe_out
);
    // pin synchronisers, first stage feeds only the second
    logic sclk_m, sclk_s, sclk_d, cs_m, cs_s, sd_m, sd_s;
    efi_sp_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [6:0] sh, next_sh;
    logic [7:0] rdsh, next_rdsh;
    logic [6:0] next_addr;
    logic rw, next_rw, next_sdio, next_oe, rise, fall;
    efi_wr_t next_wr;

    // ------------------------------------------------------------
    // frame decode; sclk must stay well below the system clock
    // ------------------------------------------------------------
    always_comb begin
        rise       = sclk_s & ~sclk_d;
        fall       = ~sclk_s & sclk_d;
        next_state = state;
        next_cnt   = cnt;
        next_sh    = sh;
        next_rdsh  = rdsh;
        next_addr  = rd_addr_out;
        next_rw    = rw;
        next_sdio  = sdio_out;
        next_oe    = sdio_oe_out;
        next_wr    = '0;
        if (cs_s) begin
            next_state = EFI_SP_IDLE;
            next_oe    = 1'b0;
        end else begin
            case (state)
                EFI_SP_IDLE: begin
                    next_state = EFI_SP_INSTR;
                    next_cnt   = 4'h0;
                end
                EFI_SP_INSTR: if (rise) begin
                    next_sh  = {sh[5:0], sd_s};
                    next_cnt = cnt + 4'h1;
                    if (cnt == EFI_LAST_BIT) begin
                        next_rw    = sh[EFI_RW_BIT-1];
                        next_addr  = {sh[5:0], sd_s};
                        next_cnt   = 4'h0;
                        next_state = EFI_SP_DATA;
                    end
                end
                EFI_SP_DATA: begin
                    if (rw && fall) begin
                        next_oe   = 1'b1;
                        next_sdio = sdio_oe_out ? rdsh[7] : rd_data_in[7];
                        next_rdsh = sdio_oe_out ? {rdsh[6:0], 1'b0}
                                                : {rd_data_in[6:0], 1'b0};
                    end
                    if (rise) begin
                        next_sh  = {sh[5:0], sd_s};
                        next_cnt = cnt + 4'h1;
                        if (cnt == EFI_LAST_BIT) begin
                            next_wr.valid = ~rw;
                            next_wr.addr  = rd_addr_out;
                            next_wr.data  = {sh, sd_s};
                            next_state    = EFI_SP_DONE;
                        end
                    end
                end
                EFI_SP_DONE: next_oe = 1'b0;
                default: next_state = EFI_SP_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            {sclk_m, sclk_s, sclk_d} <= 3'h0;
            {cs_m, cs_s}             <= 2'h3;
            {sd_m, sd_s}             <= 2'h0;
            state                    <= EFI_SP_IDLE;
            cnt                      <= 4'h0;
            sh                       <= 7'h00;
            rdsh                     <= 8'h00;
            rd_addr_out              <= 7'h00;
            rw                       <= 1'b0;
            sdio_out                 <= 1'b0;
            sdio_oe_out              <= 1'b0;
            wr_out                   <= '0;
        end else begin
            {sclk_m, sclk_s, sclk_d} <= {sclk_in, sclk_m, sclk_s};
            {cs_m, cs_s}             <= {cs_n_in, cs_m};
            {sd_m, sd_s}             <= {sdio_in, sd_m};
            state                    <= next_state;
            cnt                      <= next_cnt;
            sh                       <= next_sh;
            rdsh                     <= next_rdsh;
            rd_addr_out              <= next_addr;
            rw                       <= next_rw;
            sdio_out                 <= next_sdio;
            sdio_oe_out              <= next_oe;
            wr_out                   <= next_wr;
        end
    end
endmodule
`default_nettype wire

// [core/efi_top.sv]
// event flag and interrupt request logic with its serial register port
`timescale 1ns/10ps
`default_nettype none

module efi_top
    import efi_pkg::*;
#(
    parameter int N_FLAGS = EFI_NUM_FLAGS
) (
    input  wire logic               ref_clk_in,
    input  wire logic               rstn_in,
    input  wire logic               soft_reset_in,
    input  wire logic [N_FLAGS-1:0] event_source_in,
    input  wire logic               spi_sclk_in,
    input  wire logic               spi_cs_n_in,
    input  wire logic               spi_sdio_in,
    output logic                    spi_sdio_out,
    output logic                    spi_sdio_oe_out,
    output logic                    request_out_first_out,
    output logic                    request_out_first_oe_out,
    output logic                    request_out_second_out,
    output logic                    request_out_second_oe_out,
    output logic      [N_FLAGS-1:0] source_clear_out
);
    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (N_FLAGS <= EFI_DATA_W || N_FLAGS > EFI_PAD_W) begin : g_bad_flags
        $error("N_FLAGS must span both register pairs, 9 to 16");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    efi_wr_t                wr;
    logic [EFI_ADDR_W-1:0]  rd_addr;
    logic [EFI_DATA_W-1:0]  rd_data;
    logic [N_FLAGS-1:0]     enable;
    logic [N_FLAGS-1:0]     route;
    logic [N_FLAGS-1:0]     w1c;
    logic [N_FLAGS-1:0]     next_enable;
    logic [N_FLAGS-1:0]     next_route;
    logic [N_FLAGS-1:0]     next_w1c;
    logic [N_FLAGS-1:0]     flag;
    logic [N_FLAGS-1:0]     pending;
    logic                   first_oe;
    logic                   second_oe;
    logic                   next_first_oe;
    logic                   next_second_oe;
    logic                   pin_level;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // widen a flag vector to the full two-register span
    function automatic logic [EFI_PAD_W-1:0] pad(input logic [N_FLAGS-1:0] v);
        pad = EFI_PAD_W'(v);
    endfunction

    // low or high byte of a flag vector; unused high bits read zero
    function automatic logic [7:0] half(input logic [N_FLAGS-1:0] v,
                                        input logic                hi);
        logic [EFI_PAD_W-1:0] p;
        p    = pad(v);
        half = hi ? p[15:8] : p[7:0];
    endfunction

    // register read decode, unmapped offsets read zero
    function automatic logic [7:0] read_reg(input logic [6:0]         a,
                                            input logic [N_FLAGS-1:0] e,
                                            input logic [N_FLAGS-1:0] f,
                                            input logic [N_FLAGS-1:0] r);
        case (a)
            EFI_OFS_EN_LOW:    read_reg = half(e, 1'b0);
            EFI_OFS_EN_HIGH:   read_reg = half(e, 1'b1);
            EFI_OFS_FLAG_LOW:  read_reg = half(f, 1'b0);
            EFI_OFS_FLAG_HIGH: read_reg = half(f, 1'b1);
            EFI_OFS_RT_LOW:    read_reg = half(r, 1'b0);
            EFI_OFS_RT_HIGH:   read_reg = half(r, 1'b1);
            default:           read_reg = EFI_RD_UNMAPPED;
        endcase
    endfunction

    // merge a byte into one half of a flag vector
    function automatic logic [N_FLAGS-1:0] merge(input logic [N_FLAGS-1:0] v,
                                                 input logic                hi,
                                                 input logic [7:0]          d);
        logic [EFI_PAD_W-1:0] p;
        p = pad(v);
        if (hi) begin
            p[15:8] = d;
        end else begin
            p[7:0] = d;
        end
        merge = p[N_FLAGS-1:0];
    endfunction

    // ------------------------------------------------------------
    // serial control port
    // ------------------------------------------------------------
    efi_serial_port u_port (
        .ref_clk_in  (ref_clk_in),
        .rstn_in     (rstn_in),
        .sclk_in     (spi_sclk_in),
        .cs_n_in     (spi_cs_n_in),
        .sdio_in     (spi_sdio_in),
        .rd_data_in  (rd_data),
        .rd_addr_out (rd_addr),
        .wr_out      (wr),
        .sdio_out    (spi_sdio_out),
        .sdio_oe_out (spi_sdio_oe_out)
    );

    // read data sampled by the port on the first output edge
    assign rd_data = read_reg(rd_addr, enable, flag, route);

    // ------------------------------------------------------------
    // control registers and write-one-to-clear strobes
    // ------------------------------------------------------------
    always_comb begin
        next_enable = enable;
        next_route  = route;
        next_w1c    = '0;
        if (wr.valid) begin
            case (wr.addr)
                EFI_OFS_EN_LOW:    next_enable = merge(enable, 1'b0, wr.data);
                EFI_OFS_EN_HIGH:   next_enable = merge(enable, 1'b1, wr.data);
                EFI_OFS_FLAG_LOW:  next_w1c    = merge('0, 1'b0, wr.data);
                EFI_OFS_FLAG_HIGH: next_w1c    = merge('0, 1'b1, wr.data);
                EFI_OFS_RT_LOW:    next_route  = merge(route, 1'b0, wr.data);
                EFI_OFS_RT_HIGH:   next_route  = merge(route, 1'b1, wr.data);
                default:           next_w1c    = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            enable <= N_FLAGS'(EFI_EN_RESET);
            route  <= N_FLAGS'(EFI_RT_RESET);
            w1c    <= '0;
        end else begin
            enable <= next_enable;
            route  <= next_route;
            w1c    <= next_w1c;
        end
    end

    // the same strobe also clears conditions held at their source
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            source_clear_out <= '0;
        end else begin
            source_clear_out <= w1c;
        end
    end

    // ------------------------------------------------------------
    // flag cells
    // ------------------------------------------------------------
    for (genvar i = 0; i < N_FLAGS; i++) begin : g_flag
        efi_flag_cell u_cell (
            .ref_clk_in    (ref_clk_in),
            .rstn_in       (rstn_in),
            .soft_reset_in (soft_reset_in),
            .enable_in     (enable[i]),
            .source_in     (event_source_in[i]),
            .w1c_in        (w1c[i]),
            .flag_out      (flag[i]),
            .pending_out   (pending[i])
        );
    end

    // ------------------------------------------------------------
    // request outputs
    // ------------------------------------------------------------
    // registered so the pins never glitch on decode hazards
    always_comb begin
        next_first_oe  = |(pending & ~route);
        next_second_oe = |(pending & route);
        if (soft_reset_in) begin
            next_first_oe  = 1'b0;
            next_second_oe = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            first_oe  <= 1'b0;
            second_oe <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            first_oe  <= next_first_oe;
            second_oe <= next_second_oe;
            pin_level <= 1'b0;
        end
    end

    // open drain: only ever pull low, an external resistor lifts the line
    assign request_out_first_out     = pin_level;
    assign request_out_second_out    = pin_level;
    assign request_out_first_oe_out  = first_oe;
    assign request_out_second_oe_out = second_oe;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_open_drain;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !request_out_first_out && !request_out_second_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");

    property p_hi_pad;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (rd_addr == EFI_OFS_FLAG_HIGH) |-> (rd_data == 8'(flag >> EFI_DATA_W));
    endproperty
    a_hi_pad: assert property (p_hi_pad) else $error("flag high readback wrong");

    property p_en_write;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (wr.valid && wr.addr == EFI_OFS_EN_LOW) |=> (enable[7:0] == $past(wr.data));
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost");

    property p_first_req;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (|(pending & ~route) && !soft_reset_in) |=> first_oe;
    endproperty
    a_first_req: assert property (p_first_req) else $error("first request missing");

    property p_second_req;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (|(pending & route) && !soft_reset_in) |=> second_oe;
    endproperty
    a_second_req: assert property (p_second_req) else $error("second request missing");

    property p_disabled_quiet;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (enable == '0) |=> !first_oe && !second_oe;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled flag requested");

    property p_soft_reset;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        soft_reset_in |=> (pending == '0) ##1 (!first_oe && !second_oe);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset left events");

    property p_src_clear;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (wr.valid && wr.addr == EFI_OFS_FLAG_LOW) |=> ##1
            (source_clear_out[7:0] == $past(wr.data, 2));
    endproperty
    a_src_clear: assert property (p_src_clear) else $error("source clear mismatch");

    property p_reset_idle;
        @(posedge ref_clk_in)
        !rstn_in |=> !first_oe && !second_oe && (pending == '0);
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");

    // a disabled flag in the low register must read back exactly its live source level
    property p_live_read;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (rd_addr == EFI_OFS_FLAG_LOW) |-> (((rd_data ^ event_source_in[7:0]) & ~enable[7:0]) == 8'h00);
    endproperty
    a_live_read: assert property (p_live_read) else $error("live readback wrong");

    property p_en_high_write;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (wr.valid && wr.addr == EFI_OFS_EN_HIGH) |=>
            (enable[N_FLAGS-1:EFI_DATA_W] == $past(wr.data[N_FLAGS-EFI_DATA_W-1:0]));
    endproperty
    a_en_high_write: assert property (p_en_high_write) else $error("high enable write lost");

    property p_route_write;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        (wr.valid && wr.addr == EFI_OFS_RT_LOW) |=> (route[7:0] == $past(wr.data));
    endproperty
    a_route_write: assert property (p_route_write) else $error("route write lost");

    // a line with nothing pending routed to it must be released
    property p_first_quiet;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !(|(pending & ~route)) |=> !first_oe;
    endproperty
    a_first_quiet: assert property (p_first_quiet) else $error("first request stuck");

    property p_second_quiet;
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !(|(pending & route)) |=> !second_oe;
    endproperty
    a_second_quiet: assert property (p_second_quiet) else $error("second request stuck");
endmodule
`default_nettype wire

// [dv/efi_host_model.sv]
// host-side model: pulled-up request lines and the shared serial data wire
`timescale 1ns/10ps
`default_nettype none
module efi_host_model (
    input  wire logic first_data_in,
    input  wire logic first_oe_in,
    input  wire logic second_data_in,
    input  wire logic second_oe_in,
    input  wire logic dev_sdio_in,
    input  wire logic dev_sdio_oe_in,
    input  wire logic host_sdio_in,
    output logic      line_first_out,
    output logic      line_second_out,
    output logic      sdio_line_out
);
    // ------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------
    // external pull-up: a released line reads high, never the last level
    assign line_first_out  = first_oe_in ? first_data_in : 1'b1;
    assign line_second_out = second_oe_in ? second_data_in : 1'b1;
    // device wins the data wire while it drives, otherwise the host drives
    assign sdio_line_out   = dev_sdio_oe_in ? dev_sdio_in : host_sdio_in;
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the event flag interrupt logic
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch %s exp %h got %h", nm, exp, got); end end
module tb_top;
    import efi_pkg::*;
    localparam int HP = 8;
    logic       clk = 1'b0, rstn = 1'b0, soft_rst = 1'b0;
    logic       sclk = 1'b0, cs_n = 1'b1, host_sdio = 1'b0;
    logic [9:0] src = '0, clr_seen = '0;
    logic [7:0] q;
    int         err_count = 0, comparisons = 0, cycles = 0;
    wire logic  sdo, sdo_oe, f_d, f_oe, s_d, s_oe, request_out_first, request_out_second, sdio_line;
    wire logic [9:0] src_clr;
    efi_top #(.N_FLAGS(EFI_NUM_FLAGS)) efi_top_i (
        .ref_clk_in(clk), .rstn_in(rstn), .soft_reset_in(soft_rst),
        .event_source_in(src), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
        .spi_sdio_in(sdio_line), .spi_sdio_out(sdo), .spi_sdio_oe_out(sdo_oe),
        .request_out_first_out(f_d), .request_out_first_oe_out(f_oe),
        .request_out_second_out(s_d), .request_out_second_oe_out(s_oe),
        .source_clear_out(src_clr));
    efi_host_model efi_host_model_i (
        .first_data_in(f_d), .first_oe_in(f_oe), .second_data_in(s_d),
        .second_oe_in(s_oe), .dev_sdio_in(sdo), .dev_sdio_oe_in(sdo_oe),
        .host_sdio_in(host_sdio), .line_first_out(request_out_first),
        .line_second_out(request_out_second), .sdio_line_out(sdio_line));
    // ------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    // sticky capture: the clear pulse lasts one cycle only
    always @(posedge clk) begin
        cycles++;
        clr_seen <= clr_seen | src_clr;
        if (cycles == 30000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one frame; half period well above the four-clock minimum of the port
    task automatic sp_xfer(input logic rd, input logic [6:0] a, input logic [7:0] d);
        logic [15:0] w;
        w = {rd, a, d};
        cs_n = 1'b0;
        wt(HP);
        for (int i = 15; i >= 0; i--) begin
            host_sdio = w[i];
            sclk = 1'b0;
            wt(HP);
            if (i < 8) q[i] = sdio_line;
            sclk = 1'b1;
            wt(HP);
        end
        cs_n = 1'b1;
        sclk = 1'b0;
        wt(12);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        sp_xfer(1'b0, a, d);
    endtask
    task automatic rd(input logic [6:0] a);
        sp_xfer(1'b1, a, 8'h00);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [6:0] regs [6] = '{7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08};
        foreach (regs[i]) begin
            rd(regs[i]);
            `CHK("reg after reset", 8'h00, q)
        end
        rd(7'h10);
        `CHK("unmapped read", 8'h00, q)
        `CHK("request_out_first idle", 1'b1, request_out_first)
        `CHK("request_out_second idle", 1'b1, request_out_second)
        $display("test reset done");
    endtask
    task automatic t_live();
        src[3] = 1'b1;
        src[9] = 1'b1;
        wt(2);
        rd(EFI_OFS_FLAG_LOW);
        `CHK("live low", 8'h08, q)
        rd(EFI_OFS_FLAG_HIGH);
        `CHK("live high", 8'h02, q)
        `CHK("request_out_first disabled", 1'b1, request_out_first)
        src = '0;
        rd(EFI_OFS_FLAG_LOW);
        `CHK("live low gone", 8'h00, q)
        $display("test live done");
    endtask
    task automatic t_latch();
        wr(EFI_OFS_EN_LOW, 8'hff);
        wr(EFI_OFS_EN_HIGH, 8'h03);
        wr(EFI_OFS_RT_HIGH, 8'h02);
        rd(EFI_OFS_EN_HIGH);
        `CHK("enable high", 8'h03, q)
        rd(EFI_OFS_RT_HIGH);
        `CHK("route high", 8'h02, q)
        src[0] = 1'b1;
        wt(3);
        `CHK("request_out_first set", 1'b0, request_out_first)
        `CHK("request_out_second quiet", 1'b1, request_out_second)
        src[0] = 1'b0;
        rd(EFI_OFS_FLAG_LOW);
        `CHK("flag held", 8'h01, q)
        src[9] = 1'b1;
        wt(3);
        src[9] = 1'b0;
        `CHK("request_out_second set", 1'b0, request_out_second)
        clr_seen = '0;
        wr(EFI_OFS_FLAG_LOW, 8'h01);
        `CHK("request_out_first cleared", 1'b1, request_out_first)
        `CHK("source clear", 10'h001, clr_seen)
        `CHK("request_out_second kept", 1'b0, request_out_second)
        $display("test latch done");
    endtask
    task automatic t_service();
        rd(EFI_OFS_FLAG_HIGH);
        `CHK("service read", 8'h02, q)
        wr(EFI_OFS_EN_HIGH, 8'h00);
        `CHK("request_out_second hidden", 1'b1, request_out_second)
        rd(EFI_OFS_FLAG_HIGH);
        `CHK("cause gone", 8'h00, q)
        wr(EFI_OFS_FLAG_HIGH, 8'h02);
        wr(EFI_OFS_EN_HIGH, 8'h03);
        `CHK("request_out_second after service", 1'b1, request_out_second)
        src[1] = 1'b1;
        wt(3);
        `CHK("request_out_first again", 1'b0, request_out_first)
        soft_rst = 1'b1;
        wt(1);
        soft_rst = 1'b0;
        wt(3);
        `CHK("request_out_first soft reset", 1'b1, request_out_first)
        src[1] = 1'b0;
        rd(EFI_OFS_FLAG_LOW);
        `CHK("flags soft reset", 8'h00, q)
        wr(EFI_OFS_RT_LOW, 8'h04);
        rd(EFI_OFS_RT_LOW);
        `CHK("route low", 8'h04, q)
        src[2] = 1'b1;
        wt(3);
        `CHK("request_out_second routed", 1'b0, request_out_second)
        `CHK("request_out_first not routed", 1'b1, request_out_first)
        wr(EFI_OFS_FLAG_LOW, 8'h04);
        `CHK("request_out_second w1c", 1'b1, request_out_second)
        src[2] = 1'b0;
        $display("test service done");
    endtask
    initial begin
        wt(2);
        rstn = 1'b1;
        wt(4);
        t_reset();
        t_live();
        t_latch();
        t_service();
        end_sim();
    end
endmodule
`default_nettype wire
